/* File: tfo_pkg.sv */
// tfo_pkg: register map, field layout, reset values and encodings for the
// thermal failsafe and offset register bank.
// assumes a 32-bit classic wishbone slave; printed offsets are word indices.
package tfo_pkg;
    // printed register indices (byte address = index * 4)
    localparam logic [7:0] R1_CRIT_IDX   = 8'h6a;
    localparam logic [7:0] LOC_CRIT_IDX  = 8'h6b;
    localparam logic [7:0] R2_CRIT_IDX   = 8'h6c;
    localparam logic [7:0] R1L_HYST_IDX  = 8'h6d;
    localparam logic [7:0] R2_HYST_IDX   = 8'h6e;
    localparam logic [7:0] TEST_EN_IDX   = 8'h6f;
    localparam logic [7:0] R1_OFS_IDX    = 8'h70;
    localparam logic [7:0] LOC_OFS_IDX   = 8'h71;
    localparam logic [7:0] R2_OFS_IDX    = 8'h72;
    // own registers for loose control and status bits
    localparam logic [7:0] CTRL_IDX      = 8'h80;
    localparam logic [7:0] STAT_IDX      = 8'h81;
    localparam logic [7:0] IRQ_STAT_IDX  = 8'h82;
    localparam logic [7:0] IRQ_MASK_IDX  = 8'h83;
    localparam logic [7:0] START_IDX     = 8'h84;
    // reset values
    localparam logic [7:0] CRIT_RST      = 8'h64;
    localparam logic [7:0] R1L_HYST_RST  = 8'h44;
    localparam logic [7:0] R2_HYST_RST   = 8'h40;
    localparam logic [7:0] ZERO_RST      = 8'h00;
    localparam logic [7:0] START_RST     = 8'h5a;
    // encodings and fields
    localparam logic [7:0] CRIT_DISABLE  = 8'h80;
    localparam int         CTRL_LOCK_BIT = 0;
    localparam int         CTRL_PIN_OUT  = 1;
    localparam int         TEST_EN_BIT   = 0;
    localparam int         FRAC_BITS     = 2;
    // interrupt status bits: crit state per channel, overtemp pin assert
    localparam int         IRQ_W         = 4;
    localparam int         NCH           = 3;
endpackage : tfo_pkg

/* File: tfo_regs.sv */
// tfo_regs: critical limits, hysteresis, test enable and temperature offset
// registers, with the failsafe full-duty and fan start hysteresis logic.
// assumes raw readings in 10-bit two's complement, quarter-degree lsb,
// with a one-cycle valid strobe per channel from the measurement engine.
//
// Overview of operation
// RQ1: three 8-bit critical limits, remote 1, local, remote 2, reset to 100 degrees.
// RQ2: any channel above its critical limit forces all fan outputs to full duty.
// RQ3: a critical limit of 0x80 disables forcing for that channel.
// RQ4: forcing holds until temperature drops below limit minus channel hysteresis.
// RQ5: with the pin set as output, drive it low a quarter degree over limit.
// RQ6: with the lock bit set, every register here ignores writes; irq status and irq mask stay writable under lock.
// RQ7: 4-bit hysteresis per channel in two registers, resets 0x44 and 0x40.
// RQ8: below fan start threshold, keep minimum duty until threshold minus hysteresis.
// RQ9: hysteresis counts whole degrees, zero to fifteen.
// RQ10: software should program hysteresis of four degrees or more.
// RQ11: bit 0 of the test register enters logic-tree test mode, resets zero.
// RQ12: software must not write the upper seven test register bits.
// RQ13: signed quarter-degree offset added to every remote 1 reading, reset zero.
// RQ14: signed quarter-degree offset added to every local reading, reset zero.
// RQ15: signed quarter-degree offset added to every remote 2 reading, reset zero.
// RQ16: offsets apply before every threshold and limit comparison.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module tfo_regs (
    input  wire logic        ref_clk,             // 250 MHz clock
    input  wire logic        resetn,              // async reset, active low
    input  wire logic        wb_cyc_i,            // wishbone cycle
    input  wire logic        wb_stb_i,            // wishbone strobe
    input  wire logic        wb_we_i,             // wishbone write enable
    input  wire logic [9:0]  wb_adr_i,            // byte address
    input  wire logic [3:0]  wb_sel_i,            // byte selects
    input  wire logic [31:0] wb_dat_i,            // write data
    output logic      [31:0] wb_dat_o,            // read data
    output logic             wb_ack_o,            // wishbone acknowledge
    output logic             wb_err_o,            // unmapped address
    input  wire logic [9:0]  r1_raw,              // remote 1 raw reading
    input  wire logic [9:0]  loc_raw,             // local raw reading
    input  wire logic [9:0]  r2_raw,              // remote 2 raw reading
    input  wire logic [2:0]  raw_valid,           // reading strobes, bit per channel
    output logic      [9:0]  r1_temp,             // corrected remote 1
    output logic      [9:0]  loc_temp,            // corrected local
    output logic      [9:0]  r2_temp,             // corrected remote 2
    output logic             force_full_duty,     // all fans to full duty
    output logic      [2:0]  min_fan_duty_hold,   // fan held at minimum duty
    output logic             logic_tree_test_on,  // pin test mode
    input  wire logic        overtemp_pin_i,      // overtemp pin level in
    output logic             overtemp_pin_o,      // overtemp pin drive value
    output logic             overtemp_pin_oe,     // overtemp pin drive enable
    output logic             irq                  // level interrupt
);
    logic [7:0] crit_q [3];
    logic [7:0] ofs_q  [3];
    logic [7:0] start_q;
    logic [7:0] hyst1l_q, hyst2_q, test_q, ctrl_q;
    logic [9:0] temp_q [3];
    logic [2:0] crit_act_q, start_act_q, over_q;
    logic [tfo_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_evt;
    logic [7:0] idx;
    logic       req, wr, locked, hit, cfg_we;
    logic [7:0] rd_mux;
    logic [3:0] hyst [3];

    assign idx    = wb_adr_i[9:2];
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr     = req & wb_we_i & wb_sel_i[0] & hit;
    assign locked = ctrl_q[tfo_pkg::CTRL_LOCK_BIT];
    assign cfg_we = wr & ~locked; // RQ6
    // hysteresis nibbles: remote 1 high, local low, remote 2 high
    assign hyst[0] = hyst1l_q[7:4]; // RQ7
    assign hyst[1] = hyst1l_q[3:0]; // RQ7
    assign hyst[2] = hyst2_q[7:4];  // RQ7

    // whole-degree limit to quarter-degree scale, two zero bits appended
    function automatic logic [9:0] to_q(input logic [7:0] deg);
        to_q = {deg[7:0], 2'b00};
    endfunction : to_q

    // whole degrees of hysteresis to quarter-degree scale
    function automatic logic [9:0] hy_q(input logic [3:0] h);
        hy_q = {4'h0, h, 2'b00}; // RQ9
    endfunction : hy_q

    // signed compare a > b on quarter-degree values
    function automatic logic gt(input logic [9:0] a, input logic [9:0] b);
        gt = $signed(a) > $signed(b);
    endfunction : gt

    // one write strobe per register index
    function automatic logic hit_at(input logic en, input logic [7:0] a, input logic [7:0] at);
        hit_at = en && (a == at);
    endfunction : hit_at

    // address decode and read mux
    always_comb begin
        hit    = 1'b1;
        rd_mux = 8'h00;
        case (idx)
            tfo_pkg::R1_CRIT_IDX:  rd_mux = crit_q[0];
            tfo_pkg::LOC_CRIT_IDX: rd_mux = crit_q[1];
            tfo_pkg::R2_CRIT_IDX:  rd_mux = crit_q[2];
            tfo_pkg::R1L_HYST_IDX: rd_mux = hyst1l_q;
            tfo_pkg::R2_HYST_IDX:  rd_mux = hyst2_q;
            tfo_pkg::TEST_EN_IDX:  rd_mux = test_q;
            tfo_pkg::R1_OFS_IDX:   rd_mux = ofs_q[0];
            tfo_pkg::LOC_OFS_IDX:  rd_mux = ofs_q[1];
            tfo_pkg::R2_OFS_IDX:   rd_mux = ofs_q[2];
            tfo_pkg::CTRL_IDX:     rd_mux = ctrl_q;
            tfo_pkg::STAT_IDX:     rd_mux = {1'b0, over_q, start_act_q, force_full_duty};
            tfo_pkg::IRQ_STAT_IDX: rd_mux = {4'h0, irq_stat_q};
            tfo_pkg::IRQ_MASK_IDX: rd_mux = {4'h0, irq_mask_q};
            tfo_pkg::START_IDX:    rd_mux = start_q;
            default:               hit    = 1'b0;
        endcase
    end

    // ack one edge after a mapped request, a single pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & hit;
        end
    end

    // err one edge after an unmapped request, a single pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= req & ~hit;
        end
    end

    // read data stands with ack only, zero otherwise
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && hit && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_mux};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // critical limits; lock freezes them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            crit_q[0] <= tfo_pkg::CRIT_RST; // RQ1
            crit_q[1] <= tfo_pkg::CRIT_RST; // RQ1
            crit_q[2] <= tfo_pkg::CRIT_RST; // RQ1
        end else begin
            if (hit_at(cfg_we, idx, tfo_pkg::R1_CRIT_IDX)) begin // RQ6
                crit_q[0] <= wb_dat_i[7:0];
            end
            if (hit_at(cfg_we, idx, tfo_pkg::LOC_CRIT_IDX)) begin // RQ6
                crit_q[1] <= wb_dat_i[7:0];
            end
            if (hit_at(cfg_we, idx, tfo_pkg::R2_CRIT_IDX)) begin // RQ6
                crit_q[2] <= wb_dat_i[7:0];
            end
        end
    end

    // remote 1 and local hysteresis nibbles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hyst1l_q <= tfo_pkg::R1L_HYST_RST; // RQ7
        end else if (hit_at(cfg_we, idx, tfo_pkg::R1L_HYST_IDX)) begin // RQ6
            hyst1l_q <= wb_dat_i[7:0];
        end
    end

    // remote 2 hysteresis, low nibble unused
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hyst2_q <= tfo_pkg::R2_HYST_RST; // RQ7
        end else if (hit_at(cfg_we, idx, tfo_pkg::R2_HYST_IDX)) begin // RQ6
            hyst2_q <= wb_dat_i[7:0];
        end
    end

    // test enable; upper bits stored as written, software keeps them zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            test_q <= tfo_pkg::ZERO_RST; // RQ11
        end else if (hit_at(cfg_we, idx, tfo_pkg::TEST_EN_IDX)) begin // RQ6
            test_q <= wb_dat_i[7:0]; // RQ11
        end
    end

    // temperature offsets; lock freezes them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ofs_q[0] <= tfo_pkg::ZERO_RST; // RQ13
            ofs_q[1] <= tfo_pkg::ZERO_RST; // RQ14
            ofs_q[2] <= tfo_pkg::ZERO_RST; // RQ15
        end else begin
            if (hit_at(cfg_we, idx, tfo_pkg::R1_OFS_IDX)) begin // RQ6
                ofs_q[0] <= wb_dat_i[7:0];
            end
            if (hit_at(cfg_we, idx, tfo_pkg::LOC_OFS_IDX)) begin // RQ6
                ofs_q[1] <= wb_dat_i[7:0];
            end
            if (hit_at(cfg_we, idx, tfo_pkg::R2_OFS_IDX)) begin // RQ6
                ofs_q[2] <= wb_dat_i[7:0];
            end
        end
    end

    // control; once locked it cannot unlock until reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= tfo_pkg::ZERO_RST;
        end else if (hit_at(cfg_we, idx, tfo_pkg::CTRL_IDX)) begin // RQ6
            ctrl_q <= wb_dat_i[7:0];
        end
    end

    // shared fan start threshold
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_q <= tfo_pkg::START_RST;
        end else if (hit_at(cfg_we, idx, tfo_pkg::START_IDX)) begin // RQ6
            start_q <= wb_dat_i[7:0];
        end
    end

    // offset added to every fresh reading; offset sign extended
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            temp_q[0] <= 10'h000;
            temp_q[1] <= 10'h000;
            temp_q[2] <= 10'h000;
        end else begin
            if (raw_valid[0]) temp_q[0] <= r1_raw  + {{2{ofs_q[0][7]}}, ofs_q[0]}; // RQ13
            if (raw_valid[1]) temp_q[1] <= loc_raw + {{2{ofs_q[1][7]}}, ofs_q[1]}; // RQ14
            if (raw_valid[2]) temp_q[2] <= r2_raw  + {{2{ofs_q[2][7]}}, ofs_q[2]}; // RQ15
        end
    end

    // failsafe state per channel on corrected values only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            crit_act_q <= 3'b000;
        end else begin
            for (int c = 0; c < tfo_pkg::NCH; c++) begin
                // disable code wins; enter above limit, leave below limit minus hysteresis
                if (crit_q[c] == tfo_pkg::CRIT_DISABLE) begin
                    crit_act_q[c] <= 1'b0; // RQ3
                end else if (gt(temp_q[c], to_q(crit_q[c]))) begin
                    crit_act_q[c] <= 1'b1; // RQ2 RQ16
                end else if (gt(to_q(crit_q[c]) - hy_q(hyst[c]), temp_q[c])) begin
                    crit_act_q[c] <= 1'b0; // RQ4
                end
            end
        end
    end

    // pin trip point sits a quarter degree past the limit
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            over_q <= 3'b000;
        end else begin
            for (int c = 0; c < tfo_pkg::NCH; c++) begin
                if (crit_q[c] == tfo_pkg::CRIT_DISABLE) begin
                    over_q[c] <= 1'b0; // RQ3
                end else begin
                    over_q[c] <= gt(temp_q[c], to_q(crit_q[c]) + 10'h001); // RQ5
                end
            end
        end
    end

    // fan start band: runs above threshold, may stop below threshold minus hysteresis
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_act_q <= 3'b000;
        end else begin
            for (int c = 0; c < tfo_pkg::NCH; c++) begin
                if (gt(temp_q[c], to_q(start_q))) begin
                    start_act_q[c] <= 1'b1; // RQ8 RQ16
                end else if (gt(to_q(start_q) - hy_q(hyst[c]), temp_q[c])) begin
                    start_act_q[c] <= 1'b0; // RQ8
                end
            end
        end
    end

    // any channel in critical state drives every fan to full duty
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            force_full_duty <= 1'b0;
        end else begin
            force_full_duty <= |crit_act_q; // RQ2
        end
    end

    // per-channel hold at minimum duty inside the start band
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            min_fan_duty_hold <= 3'b000;
        end else begin
            min_fan_duty_hold <= start_act_q; // RQ8
        end
    end

    // pin test mode follows the enable bit
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            logic_tree_test_on <= 1'b0;
        end else begin
            logic_tree_test_on <= test_q[tfo_pkg::TEST_EN_BIT]; // RQ11
        end
    end

    // open drain: the value is always low, only the enable moves
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            overtemp_pin_o  <= 1'b0;
            overtemp_pin_oe <= 1'b0;
        end else begin
            overtemp_pin_o  <= 1'b0;
            overtemp_pin_oe <= ctrl_q[tfo_pkg::CTRL_PIN_OUT] & (|over_q); // RQ5
        end
    end

    // corrected readings to the outside
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r1_temp  <= 10'h000;
            loc_temp <= 10'h000;
            r2_temp  <= 10'h000;
        end else begin
            r1_temp  <= temp_q[0]; // RQ13
            loc_temp <= temp_q[1]; // RQ14
            r2_temp  <= temp_q[2]; // RQ15
        end
    end

    // events: channel in critical state, and pin seen pulled low
    assign irq_evt = {(|over_q) & ~overtemp_pin_i & ctrl_q[tfo_pkg::CTRL_PIN_OUT],
                      crit_act_q};

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= 4'h0;
        end else if (hit_at(wr, idx, tfo_pkg::IRQ_STAT_IDX)) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[3:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    // mask stays writable under lock so software can still quiet the line
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask_q <= 4'h0;
        end else if (hit_at(wr, idx, tfo_pkg::IRQ_MASK_IDX)) begin
            irq_mask_q <= wb_dat_i[3:0];
        end
    end

    // level interrupt; events count at once so the line does not lag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_q | irq_evt) & irq_mask_q);
        end
    end

endmodule : tfo_regs

/* File: tfo_regs_assertions.sv */
// tfo_regs_checker: bus timing and reading pipeline checks for tfo_regs.
// assumes one clock domain and the port names of tfo_regs; bound below.
`timescale 1ns/1ps
module tfo_regs_checker (
    input wire logic        ref_clk,        // block clock
    input wire logic        resetn,         // async reset, active low
    input wire logic        wb_cyc_i,       // bus cycle
    input wire logic        wb_stb_i,       // bus strobe
    input wire logic [9:0]  wb_adr_i,       // byte address
    input wire logic        wb_ack_o,       // acknowledge
    input wire logic        wb_err_o,       // unmapped answer
    input wire logic [2:0]  raw_valid,      // reading strobes
    input wire logic [9:0]  r1_temp,        // corrected remote 1
    input wire logic [9:0]  loc_temp,       // corrected local
    input wire logic [9:0]  r2_temp,        // corrected remote 2
    input wire logic        overtemp_pin_o  // pin drive value
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // a new request is one not already being answered
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held longer than one cycle");
    a_answer_next: assert property (req |=> (wb_ack_o ^ wb_err_o))
        else $error("request not answered next cycle");
    a_map_acked: assert property (req && wb_adr_i[9:2] inside {[8'h6a:8'h72]}
        |=> wb_ack_o)
        else $error("mapped register not acknowledged");
    a_ack_has_req: assert property (wb_ack_o |-> $past(req))
        else $error("ack without a request");
    // corrected readings only move two sampled edges after their strobe
    a_r1_strobe: assert property ($changed(r1_temp) |-> $past(raw_valid[0], 2))
        else $error("remote 1 reading moved without strobe");
    a_loc_strobe: assert property ($changed(loc_temp) |-> $past(raw_valid[1], 2))
        else $error("local reading moved without strobe");
    a_r2_strobe: assert property ($changed(r2_temp) |-> $past(raw_valid[2], 2))
        else $error("remote 2 reading moved without strobe");
    a_pin_low: assert property (!overtemp_pin_o)
        else $error("pin driven high");
endmodule : tfo_regs_checker
bind tfo_regs tfo_regs_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .raw_valid(raw_valid),
    .r1_temp(r1_temp), .loc_temp(loc_temp), .r2_temp(r2_temp),
    .overtemp_pin_o(overtemp_pin_o));

/* File: tfo_sense_model.sv */
// tfo_sense_model: measurement engine strobing three readings, plus pin pull-up.
// assumes the bench sets target readings; raw lines are junk between strobes.
`timescale 1ns/1ps
module tfo_sense_model (
    input  wire logic       ref_clk,    // block clock
    input  wire logic       resetn,     // async reset, active low
    input  wire logic [9:0] t_r1,       // remote 1 target reading
    input  wire logic [9:0] t_loc,      // local target reading
    input  wire logic [9:0] t_r2,       // remote 2 target reading
    input  wire logic       pin_o,      // pin drive value
    input  wire logic       pin_oe,     // pin drive enable
    output logic      [9:0] r1_raw,     // remote 1 raw
    output logic      [9:0] loc_raw,    // local raw
    output logic      [9:0] r2_raw,     // remote 2 raw
    output logic      [2:0] raw_valid,  // strobes
    output logic            pin         // resolved pin level
);
    logic [2:0] cnt_q;
    // one conversion round every eight cycles, all channels together
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q     <= 3'h0;
            raw_valid <= 3'h0;
        end else begin
            cnt_q     <= cnt_q + 3'h1;
            raw_valid <= {3{cnt_q == 3'h7}};
        end
    end
    // inverted value between strobes so a stale capture shows up
    assign r1_raw  = raw_valid[0] ? t_r1 : ~t_r1;
    assign loc_raw = raw_valid[1] ? t_loc : ~t_loc;
    assign r2_raw  = raw_valid[2] ? t_r2 : ~t_r2;
    assign pin     = pin_oe ? pin_o : 1'b1;  // board pull-up
endmodule : tfo_sense_model

/* File: testbench.sv */
// testbench: register, offset, failsafe, fan start and lock scenarios.
// assumes tfo_regs, tfo_sense_model and the bound checker are compiled.
`timescale 1ns/1ps
module testbench;
    logic       ref_clk, resetn, cyc, stb, we, ack, err, ffd, tst, pin, p_o, p_oe, irq;
    logic [9:0] adr, t_r1, t_loc, t_r2, r1r, lcr, r2r, r1t, lct, r2t;
    logic [2:0] rv, hold;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [7:0] rd;
    logic       er;
    int         bad_count, num_checks;
    tfo_regs dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .r1_raw(r1r), .loc_raw(lcr), .r2_raw(r2r),
        .raw_valid(rv), .r1_temp(r1t), .loc_temp(lct), .r2_temp(r2t),
        .force_full_duty(ffd), .min_fan_duty_hold(hold), .logic_tree_test_on(tst),
        .overtemp_pin_i(pin), .overtemp_pin_o(p_o), .overtemp_pin_oe(p_oe), .irq(irq));
    tfo_sense_model u_sense (.ref_clk(ref_clk), .resetn(resetn), .t_r1(t_r1),
        .t_loc(t_loc), .t_r2(t_r2), .pin_o(p_o), .pin_oe(p_oe), .r1_raw(r1r),
        .loc_raw(lcr), .r2_raw(r2r), .raw_valid(rv), .pin(pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // one classic cycle; never assumes a latency, bounded wait instead
    task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {ix, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
        rd  = rdat[7:0];
        er  = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
        if (n >= 20) begin
            bad_count++;
            end_of_test();
        end
    endtask : bus
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        bus(1'b1, ix, d);
        chk(er, 0, "write answered with err");
    endtask : wr
    task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
        bus(1'b0, ix, 8'h00);
        chk({er, rd}, {1'b0, e}, "register read");
    endtask : rdc
    // pipeline latency plus one strobe round, with margin
    task automatic settle;
        repeat (24) @(posedge ref_clk);
    endtask : settle
    task automatic t_reset_vals;
        rdc(8'h6a, 8'h64); rdc(8'h6b, 8'h64); rdc(8'h6c, 8'h64);
        rdc(8'h6d, 8'h44); rdc(8'h6e, 8'h40); rdc(8'h6f, 8'h00);
        rdc(8'h70, 8'h00); rdc(8'h71, 8'h00); rdc(8'h72, 8'h00);
        bus(1'b0, 8'h90, 8'h00);
        chk(er, 1, "unmapped read");
    endtask : t_reset_vals
    task automatic t_test_mode;
        wr(8'h6f, 8'h01); chk(tst, 1, "test mode on");
        rdc(8'h6f, 8'h01); wr(8'h6f, 8'h00); chk(tst, 0, "test mode off");
    endtask : t_test_mode
    task automatic t_offsets;
        t_r1 <= 10'h100; t_loc <= 10'h080; t_r2 <= 10'h3f0;
        wr(8'h70, 8'hfc); wr(8'h71, 8'h08); wr(8'h72, 8'h7f); settle();
        chk({r1t, lct, r2t}, {10'h0fc, 10'h088, 10'h06f}, "corrected");
        rdc(8'h72, 8'h7f); wr(8'h70, 8'h00); wr(8'h71, 8'h00); wr(8'h72, 8'h00);
    endtask : t_offsets
    // local limit 40 degrees, hysteresis 4: exit below 144 quarters
    task automatic t_failsafe;
        wr(8'h83, 8'h0f); wr(8'h80, 8'h02); wr(8'h6b, 8'h28);
        t_loc <= 10'd156; settle(); chk(ffd, 0, "below limit");
        wr(8'h71, 8'h08); settle(); chk(ffd, 1, "offset pushes over");
        chk({p_oe, pin, irq}, 3'b101, "pin and irq");
        wr(8'h71, 8'h00); t_loc <= 10'd144; settle(); chk(ffd, 1, "held at band");
        t_loc <= 10'd143; settle(); chk({ffd, p_oe}, 2'b00, "released");
        wr(8'h82, 8'h0f); chk(irq, 0, "status cleared");
        t_loc <= 10'd200; settle(); chk(ffd, 1, "over again");
        wr(8'h83, 8'h00); chk(irq, 0, "masked");
        wr(8'h6b, 8'h80); settle(); chk(ffd, 0, "disable code");
        wr(8'h82, 8'h0f); wr(8'h83, 8'h0f); chk(irq, 0, "no event left");
        wr(8'h6b, 8'h64); t_loc <= 10'h080;
    endtask : t_failsafe
    // start threshold 90 degrees, remote 1 hysteresis 4: exit below 344
    task automatic t_fan_start;
        wr(8'h6d, 8'h44);
        t_r1 <= 10'd368; settle(); chk(hold, 3'b001, "above start");
        t_r1 <= 10'd348; settle(); chk(hold, 3'b001, "inside band");
        t_r1 <= 10'd340; settle(); chk(hold, 3'b000, "below band");
    endtask : t_fan_start
    task automatic t_lock;
        // write with byte lane 0 off is acked but stores nothing
        sel <= 4'he; wr(8'h6a, 8'h22); sel <= 4'hf;
        rdc(8'h6a, 8'h64);
        wr(8'h80, 8'h01); wr(8'h6a, 8'h11); wr(8'h72, 8'h55); wr(8'h80, 8'h00);
        rdc(8'h6a, 8'h64); rdc(8'h72, 8'h00); rdc(8'h80, 8'h01);
    endtask : t_lock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        {resetn, cyc, stb, we, adr, wdat} = '0;
        sel = 4'hf;
        {t_r1, t_loc, t_r2} = {10'h100, 10'h080, 10'h0c0};
        bad_count = 0;
        num_checks = 0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset_vals(); t_test_mode(); t_offsets(); t_failsafe(); t_fan_start(); t_lock();
        end_of_test();
    end
endmodule : testbench
